// file: prcs_defs.vh
// constants for the power-on reset and configuration sequencer
// assumes: included by the sequencer module only
`ifndef PRCS_DEFS_VH
`define PRCS_DEFS_VH

// register byte addresses on the register bus
`define PRCS_ADDR_CTRL    4'h0
`define PRCS_ADDR_STATUS  4'h4
`define PRCS_ADDR_STRAPS  4'h8
`define PRCS_ADDR_CFGWORD 4'hc

// control register fields
`define PRCS_CTRL_DIV_LSB 0
`define PRCS_CTRL_DIV_MSB 3
`define PRCS_CTRL_RESET   32'h00000001

// timing counts in cycles of the named clock
`define PRCS_POR_CYCLES   16'd1024
`define PRCS_LOCK_CYCLES  16'd6400
`define PRCS_HARD_CYCLES  16'd512
`define PRCS_SOFT_CYCLES  16'd515

// sequencer states
`define PRCS_ST_HOLD   3'h0
`define PRCS_ST_POR    3'h1
`define PRCS_ST_LOCK   3'h2
`define PRCS_ST_REL    3'h3
`define PRCS_ST_RUN    3'h4

// default configuration word used by a configuration slave
`define PRCS_DEFAULT_CFG 32'h00000000

// axi response codes
`define PRCS_RESP_OKAY   2'b00
`define PRCS_RESP_SLVERR 2'b10

`endif

// file: prcs_sequencer.v
// power-on reset sequencer with strap capture and configuration word
// assumes: input_clock is aclk, straps and reset pins synchronous to it
//
// Functional notes
// - configuration word arrives through slave port or system bus path
// - bus path acts master or slave; slave without word uses default
// - fourteen strap levels sampled when power-on reset is released
// - internal power-on reset released 1024 input cycles after release
// - pll lock reached 6400 reference cycles after internal release
// - hard reset pin released 512 reference cycles after lock
// - soft reset pin released 515 reference cycles after lock
// - straps captured only at power-on reset, not on hard or soft
// - hard and soft reset are open-drain, asserted through the flow
`timescale 1ns/1ns
`include "prcs_defs.vh"

module prcs_sequencer #(
  parameter POR_CYCLES  = `PRCS_POR_CYCLES,
  parameter LOCK_CYCLES = `PRCS_LOCK_CYCLES,
  parameter HARD_CYCLES = `PRCS_HARD_CYCLES,
  parameter SOFT_CYCLES = `PRCS_SOFT_CYCLES
) (
  // clock and bus reset
  input  wire        aclk,
  input  wire        aresetn,
  // board reset and straps
  input  wire        power_on_reset_n,
  input  wire        reset_config_select,
  input  wire        config_slave_select,
  input  wire        slave_port_sync_select,
  input  wire        slave_port_wide_select,
  input  wire [3:0]  chip_number,
  input  wire [2:0]  boot_mode_sel,
  input  wire        soft_watchdog_en,
  input  wire [1:0]  clock_mode_sel,
  // configuration word from slave port path
  input  wire        slave_port_cfg_valid,
  input  wire [31:0] slave_port_cfg_word,
  // configuration word from system bus path
  input  wire        sysbus_cfg_valid,
  input  wire [31:0] sysbus_cfg_word,
  // open-drain reset pins, enable low while driving
  input  wire        hard_reset_n_in,
  output reg         hard_reset_n_out,
  output reg         hard_reset_n_oe_n,
  input  wire        soft_reset_n_in,
  output reg         soft_reset_n_out,
  output reg         soft_reset_n_oe_n,
  // sequencer state
  output reg         internal_por_n,
  output reg         system_pll_locked,
  output reg         config_master,
  output reg  [31:0] config_word,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ************************************************************
  // registers and state
  // ************************************************************
  reg  [2:0]  state;
  reg  [15:0] count;
  reg  [3:0]  ref_div;        // pll_ref_divide minus one
  reg  [3:0]  ref_cnt;
  reg  [13:0] straps;
  reg         cfg_written;
  reg  [31:0] ctrl;
  reg         aw_held;
  reg  [3:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         por_q;

  wire        ref_tick  = (ref_cnt == ref_div);
  wire        por_rise  = power_on_reset_n & ~por_q;
  wire [15:0] por_cnt   = POR_CYCLES[15:0];
  wire [15:0] lock_cnt  = LOCK_CYCLES[15:0];
  wire [15:0] hard_cnt  = HARD_CYCLES[15:0];
  wire [15:0] soft_cnt  = SOFT_CYCLES[15:0];
  wire [13:0] strap_now = {reset_config_select, config_slave_select,
                           slave_port_sync_select, slave_port_wide_select,
                           chip_number, boot_mode_sel, soft_watchdog_en,
                           clock_mode_sel};

  // ************************************************************
  // reference clock divider
  // ************************************************************
  // zero until internal release, so lock counting starts on a fresh phase
  always @(posedge aclk)
  begin
    if (!aresetn || !power_on_reset_n || state < `PRCS_ST_LOCK)
      ref_cnt <= 4'h0;
    else if (ref_tick)
      ref_cnt <= 4'h0;
    else
      ref_cnt <= ref_cnt + 4'h1;
  end

  // ************************************************************
  // reset sequence
  // ************************************************************
  // every count is dropped while power-on reset is low
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state             <= `PRCS_ST_HOLD;
      count             <= 16'h0000;
      por_q             <= 1'b0;
      straps            <= 14'h0000;
      ref_div           <= 4'h0;
      internal_por_n    <= 1'b0;
      system_pll_locked <= 1'b0;
      hard_reset_n_out  <= 1'b0;
      hard_reset_n_oe_n <= 1'b0;
      soft_reset_n_out  <= 1'b0;
      soft_reset_n_oe_n <= 1'b0;
    end
    else
    begin
      por_q <= power_on_reset_n;
      if (!power_on_reset_n)
      begin
        state             <= `PRCS_ST_HOLD;
        count             <= 16'h0000;
        internal_por_n    <= 1'b0;
        system_pll_locked <= 1'b0;
        hard_reset_n_oe_n <= 1'b0;
        soft_reset_n_oe_n <= 1'b0;
      end
      else
      begin
        case (state)
          `PRCS_ST_HOLD:
          begin
            if (por_rise)
            begin
              straps  <= strap_now;
              ref_div <= ctrl[`PRCS_CTRL_DIV_MSB:`PRCS_CTRL_DIV_LSB];
              count   <= 16'h0001;
              state   <= `PRCS_ST_POR;
            end
          end
          `PRCS_ST_POR:
          begin
            if (count == por_cnt)
            begin
              internal_por_n <= 1'b1;
              count          <= 16'h0000;
              state          <= `PRCS_ST_LOCK;
            end
            else
              count <= count + 16'h0001;
          end
          `PRCS_ST_LOCK:
          begin
            if (ref_tick)
            begin
              if (count == lock_cnt - 16'h0001)
              begin
                system_pll_locked <= 1'b1;
                count             <= 16'h0000;
                state             <= `PRCS_ST_REL;
              end
              else
                count <= count + 16'h0001;
            end
          end
          `PRCS_ST_REL:
          begin
            if (ref_tick)
            begin
              count <= count + 16'h0001;
              if (count == hard_cnt - 16'h0001)
                hard_reset_n_oe_n <= 1'b1;
              if (count == soft_cnt - 16'h0001)
              begin
                soft_reset_n_oe_n <= 1'b1;
                state             <= `PRCS_ST_RUN;
              end
            end
          end
          `PRCS_ST_RUN:
            state <= `PRCS_ST_RUN;
          default:
            state <= `PRCS_ST_HOLD;
        endcase
      end
      hard_reset_n_out <= 1'b0;
      soft_reset_n_out <= 1'b0;
    end
  end

  // ************************************************************
  // configuration word capture
  // ************************************************************
  // slave port accepted only during power-on flow; bus path while the
  // hard reset pin is still held, which is during the power-on flow only
  always @(posedge aclk)
  begin
    if (!aresetn || !power_on_reset_n)
    begin
      config_word   <= `PRCS_DEFAULT_CFG;
      cfg_written   <= 1'b0;
      config_master <= 1'b0;
    end
    else
    begin
      config_master <= ~(por_rise ? config_slave_select : straps[12]);
      if (state != `PRCS_ST_RUN && !straps[13] && slave_port_cfg_valid)
      begin
        config_word <= slave_port_cfg_word;
        cfg_written <= 1'b1;
      end
      else if (!hard_reset_n_oe_n && straps[13] && sysbus_cfg_valid)
      begin
        config_word <= sysbus_cfg_word;
        cfg_written <= 1'b1;
      end
    end
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  // address and data are held independently; response after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PRCS_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      ctrl          <= `PRCS_CTRL_RESET;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `PRCS_ADDR_CTRL)
        begin
          s_axi_bresp <= `PRCS_RESP_OKAY;
          if (w_strb[0])
            ctrl[7:0] <= w_data[7:0];
        end
        else if (aw_addr == `PRCS_ADDR_STATUS ||
                 aw_addr == `PRCS_ADDR_STRAPS ||
                 aw_addr == `PRCS_ADDR_CFGWORD)
          s_axi_bresp <= `PRCS_RESP_OKAY;     // read-only, write ignored
        else
          s_axi_bresp <= `PRCS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle to arready, data the cycle after
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PRCS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PRCS_RESP_OKAY;
        case (s_axi_araddr)
          `PRCS_ADDR_CTRL:
            s_axi_rdata <= ctrl;
          `PRCS_ADDR_STATUS:
            s_axi_rdata <= {23'h000000, cfg_written, config_master,
                            hard_reset_n_in, soft_reset_n_in,
                            system_pll_locked, internal_por_n, state};
          `PRCS_ADDR_STRAPS:
            s_axi_rdata <= {18'h00000, straps};
          `PRCS_ADDR_CFGWORD:
            s_axi_rdata <= config_word;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PRCS_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // prcs_sequencer

// file: prcs_chk_sva.sv
// checker for the reset sequencer outputs
// assumes: bound into prcs_sequencer, one clock domain
`timescale 1ns/1ns
module prcs_chk #(
  parameter POR_CYCLES  = 1024,
  parameter LOCK_CYCLES = 6400,
  parameter HARD_CYCLES = 512,
  parameter SOFT_CYCLES = 515
) (
  // clock and board inputs
  input wire        aclk,
  input wire        aresetn,
  input wire        power_on_reset_n,
  input wire        config_slave_select,
  // sequencer outputs
  input wire        hard_reset_n_out,
  input wire        hard_reset_n_oe_n,
  input wire        soft_reset_n_oe_n,
  input wire        internal_por_n,
  input wire        system_pll_locked,
  input wire        config_master,
  input wire [31:0] config_word
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles each level has held; runs stay far below the wrap
  reg [15:0] c_por, c_ipor, c_lock, c_hard;
  always @(posedge aclk)
  begin
    c_por  <= power_on_reset_n ? c_por + 16'h1 : 16'h0;
    c_ipor <= internal_por_n ? c_ipor + 16'h1 : 16'h0;
    c_lock <= system_pll_locked ? c_lock + 16'h1 : 16'h0;
    c_hard <= hard_reset_n_oe_n ? c_hard + 16'h1 : 16'h0;
  end
  // ****************
  // timing and pins
  // ****************
  AST_IPOR_TIME: assert property ($rose(internal_por_n) |->
    c_por == POR_CYCLES || c_por == POR_CYCLES + 1) else $error("ipor time");
  AST_RESTART: assert property (!power_on_reset_n |=>
    !internal_por_n && !system_pll_locked) else $error("no restart");
  AST_PINS_HELD: assert property (!internal_por_n |->
    !hard_reset_n_oe_n && !soft_reset_n_oe_n && !hard_reset_n_out)
    else $error("pin released early");
  AST_SOFT_AFTER: assert property (!hard_reset_n_oe_n |->
    !soft_reset_n_oe_n) else $error("soft before hard");
  AST_LOCK_TIME: assert property ($rose(system_pll_locked) |->
    c_ipor >= LOCK_CYCLES && c_ipor <= 2 * LOCK_CYCLES + 2)
    else $error("lock time");
  AST_HARD_TIME: assert property ($rose(hard_reset_n_oe_n) |->
    c_lock >= HARD_CYCLES && c_lock <= 2 * HARD_CYCLES + 2)
    else $error("hard time");
  AST_SOFT_TIME: assert property ($rose(soft_reset_n_oe_n) |->
    c_hard >= SOFT_CYCLES - HARD_CYCLES
    && c_hard <= 2 * (SOFT_CYCLES - HARD_CYCLES) + 2) else $error("soft time");
  AST_CAPTURE: assert property ($rose(power_on_reset_n) |=>
    config_master == !$past(config_slave_select)) else $error("capture");
  AST_STRAP_HOLD: assert property ($past(power_on_reset_n, 2)
    && $past(power_on_reset_n) |-> $stable(config_master))
    else $error("strap moved");
  AST_CFG_DEFAULT: assert property (!power_on_reset_n |=>
    config_word == 32'h0) else $error("config word kept");
endmodule // prcs_chk

bind prcs_sequencer prcs_chk #(.POR_CYCLES(POR_CYCLES),
  .LOCK_CYCLES(LOCK_CYCLES), .HARD_CYCLES(HARD_CYCLES),
  .SOFT_CYCLES(SOFT_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .power_on_reset_n(power_on_reset_n),
  .config_slave_select(config_slave_select),
  .hard_reset_n_out(hard_reset_n_out),
  .hard_reset_n_oe_n(hard_reset_n_oe_n),
  .soft_reset_n_oe_n(soft_reset_n_oe_n),
  .internal_por_n(internal_por_n), .system_pll_locked(system_pll_locked),
  .config_master(config_master), .config_word(config_word));

// file: prcs_board.sv
// board reset controller: power-on reset, straps, pin pull-ups
// assumes: por_req is a one-cycle request from the bench
`timescale 1ns/1ns
module prcs_board #(
  parameter HOLD = 16
) (
  // clock and bench commands
  input  wire        aclk,
  input  wire        por_req,
  input  wire [13:0] straps_set,
  // board outputs
  output reg         power_on_reset_n,
  output reg  [13:0] straps,
  // open-drain reset pins
  input  wire        hard_reset_n_out,
  input  wire        hard_reset_n_oe_n,
  input  wire        soft_reset_n_out,
  input  wire        soft_reset_n_oe_n,
  output wire        hard_reset_n_in,
  output wire        soft_reset_n_in
);
  reg [5:0] hold_cnt = 6'h3f;
  initial power_on_reset_n = 1'b0;
  initial straps = 14'h0;
  // straps are scrambled soon after release so late capture shows
  always @(posedge aclk)
  begin
    if (por_req)
    begin
      power_on_reset_n <= 1'b0;
      hold_cnt <= 6'h0;
      straps <= straps_set;
    end
    else if (hold_cnt != 6'h3f)
      hold_cnt <= hold_cnt + 6'h1;
    if (!por_req && hold_cnt == HOLD)
      power_on_reset_n <= 1'b1;
    if (!por_req && hold_cnt == HOLD + 2)
      straps <= ~straps_set;
  end
  // pull-ups: a released pin reads high
  assign hard_reset_n_in = hard_reset_n_oe_n ? 1'b1 :
                           hard_reset_n_out;
  assign soft_reset_n_in = soft_reset_n_oe_n ? 1'b1 : soft_reset_n_out;
endmodule // prcs_board

// file: tb.sv
// bench for the reset sequencer: bus tasks and power-on runs
// assumes: board model prcs_board, checker bound to the design
`timescale 1ns/1ns
module tb;
  localparam P = 8, L = 16, H = 4, S = 6;
  reg         aclk = 0, aresetn = 0, por_req = 0, sp_valid = 0, sb_valid = 0;
  reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg  [13:0] straps_set = 14'h0;
  reg  [3:0]  awaddr = 4'h0, araddr = 4'h0;
  reg  [31:0] wdata = 32'h0, cfg_in = 32'h0, rd;
  reg  [4:0]  ev_d = 5'h0;
  wire [13:0] st;
  wire        por_n, hr_out, hr_oe_n, hr_in, sr_out, sr_oe_n, sr_in;
  wire        ipor_n, locked, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, cfg_word;
  integer     fail_count = 0, num_checks = 0, cyc = 0, i;
  integer     t [0:4];
  wire [4:0]  ev = {sr_oe_n, hr_oe_n, locked, ipor_n, por_n};
  always #2 aclk = ~aclk;
  // stamp the cycle of each rising event
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    ev_d <= ev;
    for (i = 0; i < 5; i = i + 1)
      if (ev[i] && !ev_d[i]) t[i] <= cyc;
  end
  prcs_board u_board (.aclk(aclk), .por_req(por_req),
    .straps_set(straps_set), .power_on_reset_n(por_n), .straps(st),
    .hard_reset_n_out(hr_out), .hard_reset_n_oe_n(hr_oe_n),
    .soft_reset_n_out(sr_out), .soft_reset_n_oe_n(sr_oe_n),
    .hard_reset_n_in(hr_in), .soft_reset_n_in(sr_in));
  prcs_sequencer #(.POR_CYCLES(P), .LOCK_CYCLES(L), .HARD_CYCLES(H),
    .SOFT_CYCLES(S)) dut (.aclk(aclk), .aresetn(aresetn),
    .power_on_reset_n(por_n), .reset_config_select(st[13]),
    .config_slave_select(st[12]), .slave_port_sync_select(st[11]),
    .slave_port_wide_select(st[10]), .chip_number(st[9:6]),
    .boot_mode_sel(st[5:3]), .soft_watchdog_en(st[2]),
    .clock_mode_sel(st[1:0]), .slave_port_cfg_valid(sp_valid),
    .slave_port_cfg_word(cfg_in), .sysbus_cfg_valid(sb_valid),
    .sysbus_cfg_word(cfg_in), .hard_reset_n_in(hr_in),
    .hard_reset_n_out(hr_out), .hard_reset_n_oe_n(hr_oe_n),
    .soft_reset_n_in(sr_in), .soft_reset_n_out(sr_out),
    .soft_reset_n_oe_n(sr_oe_n), .internal_por_n(ipor_n),
    .system_pll_locked(locked), .config_master(), .config_word(cfg_word),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ****************
  // checks and bus
  // ****************
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks=%0d failures=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // a wait that ran out is a mismatch
  task hang;
  begin
    chk(32'h1, 32'h0);
    give_verdict;
  end
  endtask
  task axi_wr(input [3:0] a, input [31:0] d);
    integer n;
  begin
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n = n + 1)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        chk(bresp, 0);
        n = 99;
      end
    end
    if (n == 50) hang;
  end
  endtask
  // read one word and compare the masked bits
  task axi_rd(input [3:0] a, input [31:0] m, input [31:0] e);
    integer n;
  begin
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n = n + 1)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        rd = rdata;
        chk(rresp, 0);
        n = 99;
      end
    end
    if (n == 50) hang;
    chk(rd & m, e);
  end
  endtask
  task wait_hi(input integer k);
    integer n;
  begin
    for (n = 0; n < 400 && ev[k] !== 1'b1; n = n + 1)
      @(posedge aclk);
    if (n == 400) hang;
  end
  endtask
  // one power-on run; ab restarts it in mid count
  task run(input [13:0] s, input [3:0] dv, input [1:0] src,
    input [31:0] w, input ab);
  begin
    axi_wr(4'h0, {28'h0, dv});
    straps_set <= s;
    por_req <= 1'b1;
    @(posedge aclk);
    por_req <= 1'b0;
    // the old run's release still shows until the low level arrives
    repeat (2) @(posedge aclk);
    wait_hi(1);
    if (ab)
    begin
      por_req <= 1'b1;
      @(posedge aclk);
      por_req <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(ipor_n, 0);
      chk(hr_in, 0);
      wait_hi(1);
    end
    cfg_in <= w;
    sp_valid <= src[0];
    sb_valid <= src[1];
    @(posedge aclk);
    sp_valid <= 1'b0;
    sb_valid <= 1'b0;
    wait_hi(4);
    @(posedge aclk);
    chk(t[1] - t[0], P + 1);
    chk(t[2] - t[1], L * (dv + 1));
    chk(t[3] - t[2], H * (dv + 1));
    chk(t[4] - t[2], S * (dv + 1));
    chk(cfg_word, w);
    axi_rd(4'hc, 32'hffffffff, w);
    axi_wr(4'h8, 32'hffffffff);
    axi_rd(4'h8, 32'h3fff, {18'h0, s});
    axi_rd(4'h4, 32'hf8, {24'h0, ~s[12], 7'h78});
    $display("power-on run done, straps %h", s);
  end
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h0, 32'hf, 32'h1);
    run(14'h0a5c, 4'h0, 2'b01, 32'hc0de1234, 1'b0);
    run(14'h35a3, 4'h1, 2'b10, 32'h5a5a0ff0, 1'b0);
    run(14'h3000, 4'h1, 2'b00, 32'h0, 1'b0);
    run(14'h1fff, 4'h0, 2'b01, 32'h1234abcd, 1'b1);
    give_verdict;
  end
endmodule // tb
